// >>> proc_ctrl_map.svh
// Register offsets, field positions and reset values of the processor control group.
// Assumes inclusion by its bare name from any file that needs the map.
`ifndef PROC_CTRL_MAP_SVH
`define PROC_CTRL_MAP_SVH

`define ADDR_PROCESSOR_FLAGS      16'hc000
`define ADDR_REGISTER_WINDOW_BASE 16'hc002
`define ADDR_SILICON_REVISION     16'hc004
`define ADDR_CORE_CLOCK_DIVIDER   16'hc008
`define ADDR_POWER_CONTROL        16'hc00a
`define ADDR_INTERRUPT_ENABLE     16'hc00e
`define ADDR_BREAKPOINT_ADDRESS   16'hc014
`define ADDR_USB_DIAGNOSTIC       16'hc03c

`define RST_REGISTER_WINDOW_BASE  16'h0100
`define RST_CORE_CLOCK_DIVIDER    4'hf
`define RST_POWER_CONTROL         16'h0000
`define RST_INTERRUPT_ENABLE      16'h0010
`define RST_BREAKPOINT_ADDRESS    16'h0000
`define RST_USB_DIAGNOSTIC        16'h0000

`define WINDOW_BASE_MASK          16'hffe0
`define POWER_CONTROL_MASK        16'h5b93
`define INTERRUPT_ENABLE_MASK     16'h1bef
`define POWER_BOOST_BIT           2

`define FLAG_GIE_BIT              4
`define FLAG_NEG_BIT              3
`define FLAG_OVF_BIT              2
`define FLAG_CARRY_BIT            1
`define FLAG_ZERO_BIT             0

`define SILICON_REVISION_CODE     16'h0a5c

`define AXI_RESP_OKAY             2'h0
`define AXI_RESP_SLVERR           2'h2

`endif

// >>> proc_ctrl_pkg.sv
// Types shared by the processor control register group.
// Assumes the map header supplies all numeric constants.
package proc_ctrl_pkg;

  // Flag inputs reported by the core after each instruction.
  typedef struct packed {
    logic global_int_enable;
    logic negative;
    logic overflow;
    logic carry;
    logic zero;
  } core_flags_t;

  // Write request as held by the bus slave.
  typedef struct packed {
    logic [15:0] addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } bus_write_t;

  typedef enum logic [1:0] {
    wr_idle,
    wr_resp
  } write_state_t;

endpackage : proc_ctrl_pkg

// >>> core_clock_divider.sv
// Divider that turns the divisor field into a one-cycle core enable pulse.
// Assumes a single system clock; peripherals never see this enable.
`timescale 1ns/1ps
`include "proc_ctrl_map.svh"

module core_clock_divider (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst,
  // Divisor field, ratio is value plus one.
  input  wire logic [3:0] divisor,
  // Core advance enable.
  output logic            core_enable
);

  logic [3:0] count;

  // Comparing with >= lets a smaller divisor end the running period at once, so the
  // count never has to wrap through sixteen cycles before the new ratio applies.
  always_ff @(posedge clk) begin
    if (rst) begin
      count <= 4'h0;
    end else if (count >= divisor) begin
      count <= 4'h0;
    end else begin
      count <= count + 4'h1;
    end
  end

  assign core_enable = (count >= divisor);

endmodule : core_clock_divider

// >>> processor_control_regs.sv
// Processor control register group reached over AXI4-Lite with 32-bit data.
// Assumes byte addresses equal the 16-bit printed offsets in the low address bits,
// and that the core supplies its flags and register numbers synchronously to clk.
//
// Summary of operation
// - Flags word at 0xc000, read-only, upper bits zero.
// - Bit 4 shows global interrupt enable.
// - Bit 3 follows result most significant bit.
// - Bit 2 shows arithmetic overflow.
// - Bit 1 shows carry or borrow.
// - Bit 0 shows zero result.
// - Window base read/write, resets to 0x0100.
// - Register address is masked base OR shifted number.
// - Fixed revision code at 0xc004, read-only.
// - Core runs at clock over divisor plus one.
// - Divisor slows only the core, not peripherals.
// - Eight words decoded, breakpoint and diagnostic included.
// - Power and interrupt enables reset zero, bit4 one.
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
`include "proc_ctrl_map.svh"

module processor_control_regs (
  // Clock and reset.
  input  wire logic                       clk,
  input  wire logic                       rst,
  // AXI4-Lite write address channel.
  input  wire logic [31:0]                s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  // AXI4-Lite write data channel.
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  // AXI4-Lite write response channel.
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  // AXI4-Lite read address channel.
  input  wire logic [31:0]                s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  // AXI4-Lite read data channel.
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  // Core flag report.
  input  wire logic                       flags_update,
  input  wire proc_ctrl_pkg::core_flags_t flags_in,
  // Register window lookup from the core.
  input  wire logic [3:0]                 general_register_window,
  output logic [15:0]                     window_ram_addr,
  // Core clocking.
  output logic                            core_enable,
  output logic                            periph_enable,
  // Boost status input and control outputs to the rest of the chip.
  input  wire logic                       boost_not_ok,
  output logic [15:0]                     power_control,
  output logic [15:0]                     interrupt_enable,
  output logic [15:0]                     breakpoint_address,
  output logic [15:0]                     usb_diagnostic,
  output logic                            usb_diagnostic_strobe
);

  // Stored registers.
  proc_ctrl_pkg::core_flags_t   flags;
  logic [15:0]                  register_window_base;
  logic [3:0]                   divisor;
  // Write side holding registers.
  logic                         aw_held;
  logic                         w_held;
  proc_ctrl_pkg::bus_write_t    wr;
  proc_ctrl_pkg::write_state_t  wr_state;
  logic                         wr_fire;
  logic                         wr_hit;
  logic                         rd_hit;
  logic [15:0]                  rd_value;
  logic [15:0]                  next_ram_addr;

  // Returns true when the address names one of the eight decoded words.
  function automatic logic decode_hit(input logic [31:0] addr);
    logic [15:0] a;
    a = addr[15:0];
    if (addr[31:16] != 16'h0000) begin
      decode_hit = 1'b0;
    end else if (a == `ADDR_PROCESSOR_FLAGS || a == `ADDR_REGISTER_WINDOW_BASE) begin
      decode_hit = 1'b1;
    end else if (a == `ADDR_SILICON_REVISION || a == `ADDR_CORE_CLOCK_DIVIDER) begin
      decode_hit = 1'b1;
    end else if (a == `ADDR_POWER_CONTROL || a == `ADDR_INTERRUPT_ENABLE) begin
      decode_hit = 1'b1;
    end else if (a == `ADDR_BREAKPOINT_ADDRESS || a == `ADDR_USB_DIAGNOSTIC) begin
      decode_hit = 1'b1;
    end else begin
      decode_hit = 1'b0;
    end
  endfunction : decode_hit

  // Merges the low two byte lanes of a write into a 16-bit register.
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
    merge16 = old;
    if (strb[0]) begin
      merge16[7:0] = data[7:0];
    end
    if (strb[1]) begin
      merge16[15:8] = data[15:8];
    end
  endfunction : merge16

  // Address and data are accepted independently and held until the write fires; neither is taken again until the response leaves.
  assign s_axi_awready = !aw_held && wr_state == proc_ctrl_pkg::wr_idle;
  assign s_axi_wready  = !w_held && wr_state == proc_ctrl_pkg::wr_idle;
  assign wr_fire       = aw_held && w_held && wr_state == proc_ctrl_pkg::wr_idle;
  assign wr_hit        = decode_hit({16'h0000, wr.addr});

  // Capture of the write address.
  always_ff @(posedge clk) begin
    if (rst) begin
      aw_held <= 1'b0;
      wr.addr <= 16'h0000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      wr.addr <= (s_axi_awaddr[31:16] != 16'h0000) ? 16'h0001 : s_axi_awaddr[15:0];
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  // Capture of the write data.
  always_ff @(posedge clk) begin
    if (rst) begin
      w_held  <= 1'b0;
      wr.data <= 32'h0000_0000;
      wr.strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held  <= 1'b1;
      wr.data <= s_axi_wdata;
      wr.strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  // Write response; unmapped addresses answer with a slave error.
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_state     <= proc_ctrl_pkg::wr_idle;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `AXI_RESP_OKAY;
    end else begin
      case (wr_state)
        proc_ctrl_pkg::wr_idle: begin
          if (wr_fire) begin
            wr_state     <= proc_ctrl_pkg::wr_resp;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
          end
        end
        proc_ctrl_pkg::wr_resp: begin
          if (s_axi_bready) begin
            wr_state     <= proc_ctrl_pkg::wr_idle;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: begin
          wr_state <= proc_ctrl_pkg::wr_idle;
        end
      endcase
    end
  end

  // Writable registers; flags and revision have no write path at all.
  always_ff @(posedge clk) begin
    if (rst) begin
      register_window_base <= `RST_REGISTER_WINDOW_BASE;
      divisor              <= `RST_CORE_CLOCK_DIVIDER;
      power_control        <= `RST_POWER_CONTROL;
      interrupt_enable     <= `RST_INTERRUPT_ENABLE;
      breakpoint_address   <= `RST_BREAKPOINT_ADDRESS;
      usb_diagnostic       <= `RST_USB_DIAGNOSTIC;
    end else if (wr_fire) begin
      if (wr.addr == `ADDR_REGISTER_WINDOW_BASE) begin
        register_window_base <= merge16(register_window_base, wr.data, wr.strb);
      end else if (wr.addr == `ADDR_CORE_CLOCK_DIVIDER) begin
        if (wr.strb[0]) begin
          divisor <= wr.data[3:0];
        end
      end else if (wr.addr == `ADDR_POWER_CONTROL) begin
        power_control <= merge16(power_control, wr.data, wr.strb) & `POWER_CONTROL_MASK;
      end else if (wr.addr == `ADDR_INTERRUPT_ENABLE) begin
        // Reserved bits, bit 4 among them, keep their reset value through any write.
        interrupt_enable <= (merge16(interrupt_enable, wr.data, wr.strb)
                            & `INTERRUPT_ENABLE_MASK)
                            | (interrupt_enable & ~`INTERRUPT_ENABLE_MASK);
      end else if (wr.addr == `ADDR_BREAKPOINT_ADDRESS) begin
        breakpoint_address <= merge16(breakpoint_address, wr.data, wr.strb);
      end else if (wr.addr == `ADDR_USB_DIAGNOSTIC) begin
        usb_diagnostic <= merge16(usb_diagnostic, wr.data, wr.strb);
      end
    end
  end

  // One-cycle pulse tells the USB block that a diagnostic word was written.
  always_ff @(posedge clk) begin
    if (rst) begin
      usb_diagnostic_strobe <= 1'b0;
    end else begin
      usb_diagnostic_strobe <= wr_fire && wr.addr == `ADDR_USB_DIAGNOSTIC;
    end
  end

  // Flags follow the core's report of each executed instruction.
  always_ff @(posedge clk) begin
    if (rst) begin
      flags <= '0;
    end else if (flags_update) begin
      flags.global_int_enable <= flags_in.global_int_enable;
      flags.negative          <= flags_in.negative;
      flags.overflow          <= flags_in.overflow;
      flags.carry             <= flags_in.carry;
      flags.zero              <= flags_in.zero;
    end
  end

  // Read mux; the write-only word reads as zero, and reserved interrupt enable bit 4 reads as one.
  always_comb begin
    rd_value = 16'h0000;
    rd_hit   = decode_hit(s_axi_araddr);
    if (s_axi_araddr[15:0] == `ADDR_PROCESSOR_FLAGS) begin
      rd_value = {11'h000, flags};
    end else if (s_axi_araddr[15:0] == `ADDR_REGISTER_WINDOW_BASE) begin
      rd_value = register_window_base;
    end else if (s_axi_araddr[15:0] == `ADDR_SILICON_REVISION) begin
      rd_value = `SILICON_REVISION_CODE;
    end else if (s_axi_araddr[15:0] == `ADDR_CORE_CLOCK_DIVIDER) begin
      rd_value = {12'h000, divisor};
    end else if (s_axi_araddr[15:0] == `ADDR_POWER_CONTROL) begin
      rd_value = power_control;
      rd_value[`POWER_BOOST_BIT] = boost_not_ok;
    end else if (s_axi_araddr[15:0] == `ADDR_INTERRUPT_ENABLE) begin
      rd_value = interrupt_enable;
    end else if (s_axi_araddr[15:0] == `ADDR_BREAKPOINT_ADDRESS) begin
      rd_value = breakpoint_address;
    end
  end

  // Read channel: one read at a time, answered the cycle after the address.
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `AXI_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_hit ? {16'h0000, rd_value} : 32'h0000_0000;
      s_axi_rresp  <= rd_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Reserved low base bits are masked so a careless write cannot overlap the register number.
  assign next_ram_addr = ((register_window_base & `WINDOW_BASE_MASK)
                         | {11'h000, general_register_window, 1'b0}) & 16'hfffe;

  always_ff @(posedge clk) begin
    if (rst) begin
      window_ram_addr <= 16'h0000;
    end else begin
      window_ram_addr <= next_ram_addr;
    end
  end

  // Only the core enable is divided; peripheral logic keeps every cycle.
  assign periph_enable = 1'b1;

  core_clock_divider u_divider (
    .clk         (clk),
    .rst         (rst),
    .divisor     (divisor),
    .core_enable (core_enable)
  );

endmodule : processor_control_regs

// >>> processor_control_regs_chk.sv
// Concurrent checks on the ports of the processor control register group.
// Assumes one clock domain and the synchronous active-high reset of the design.
`timescale 1ns/1ps
`include "proc_ctrl_map.svh"

module processor_control_regs_chk (
  // Clock and reset.
  input wire logic                       clk,
  input wire logic                       rst,
  // Bus handshakes and read data.
  input wire logic                       s_axi_awvalid,
  input wire logic                       s_axi_awready,
  input wire logic                       s_axi_wvalid,
  input wire logic                       s_axi_wready,
  input wire logic                       s_axi_bvalid,
  input wire logic [31:0]                s_axi_araddr,
  input wire logic                       s_axi_arvalid,
  input wire logic                       s_axi_arready,
  input wire logic [31:0]                s_axi_rdata,
  input wire logic                       s_axi_rvalid,
  // Core side.
  input wire logic                       flags_update,
  input wire proc_ctrl_pkg::core_flags_t flags_in,
  input wire logic [3:0]                 general_register_window,
  input wire logic [15:0]                window_ram_addr,
  input wire logic                       core_enable,
  input wire logic                       periph_enable
);
  logic [15:0] rd_addr;
  logic [4:0]  flags_seen;
  logic [4:0]  gap;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // Remember the read address so that read data can be tied to the word it names.
  always_ff @(posedge clk) begin
    if (rst) rd_addr <= 16'h0000;
    else if (s_axi_arvalid && s_axi_arready) rd_addr <= s_axi_araddr[15:0];
  end

  // Shadow of the last flag report; the word must never show anything else.
  always_ff @(posedge clk) begin
    if (rst) flags_seen <= 5'h00;
    else if (flags_update) flags_seen <= flags_in;
  end

  // Cycles since the last core pulse; the slowest ratio allows sixteen.
  always_ff @(posedge clk) begin
    if (rst || core_enable) gap <= 5'h00;
    else if (gap != 5'h1f) gap <= gap + 5'h01;
  end

  sequence s_write_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_write_answer;
    ##[1:2] s_axi_bvalid;
  endsequence

  a_write_answer: assert property (s_write_taken |-> s_write_answer)
    else $error("write response missing");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data missing");
  a_flags_word: assert property (
    s_axi_rvalid && rd_addr == `ADDR_PROCESSOR_FLAGS |-> s_axi_rdata == {27'h0, flags_seen})
    else $error("flags word wrong");
  a_revision_word: assert property (
    s_axi_rvalid && rd_addr == `ADDR_SILICON_REVISION
    |-> s_axi_rdata == {16'h0000, `SILICON_REVISION_CODE})
    else $error("revision word wrong");
  a_diag_reads_zero: assert property (
    s_axi_rvalid && rd_addr == `ADDR_USB_DIAGNOSTIC |-> s_axi_rdata == 32'h0)
    else $error("diagnostic word readable");
  a_window_low_bits: assert property (
    !$past(rst) |-> window_ram_addr[4:0] == {$past(general_register_window), 1'h0})
    else $error("window address low bits wrong");
  a_core_pulse_gap: assert property (gap < 5'h11)
    else $error("core pulse too late");
  a_periph_undivided: assert property (periph_enable)
    else $error("peripheral enable divided");
endmodule : processor_control_regs_chk

bind processor_control_regs processor_control_regs_chk chk_i (
  .clk(clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .flags_update(flags_update),
  .flags_in(flags_in), .general_register_window(general_register_window),
  .window_ram_addr(window_ram_addr), .core_enable(core_enable), .periph_enable(periph_enable)
);

// >>> processor_control_regs_tb_top.sv
// Self-checking bench for the processor control register group over AXI4-Lite.
// Assumes the map header constants and a design that answers within a few cycles.
`timescale 1ns/1ps
`include "proc_ctrl_map.svh"

module processor_control_regs_tb_top;
  // Bench side of every design port, the driven inputs given values at time zero.
  logic                       clk = 1'h0;
  logic                       rst = 1'h1;
  logic [31:0]                awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
  logic [3:0]                 wstrb = 4'h0, grw = 4'h0;
  logic [1:0]                 bresp, rresp;
  logic                       awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, flags_update = 1'h0;
  logic                       arvalid = 1'h0, rready = 1'h0, boost_not_ok = 1'h0;
  logic                       awready, wready, bvalid, arready, rvalid, core_enable, periph_enable;
  logic [15:0]                wra, bkp, diag, pwr, ien;
  logic                       diag_strobe;
  int                         strobes = 0;
  proc_ctrl_pkg::core_flags_t flags_in = 5'h00;
  int                         errors = 0;
  int                         check_count = 0;

  processor_control_regs uut (
    .clk(clk), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .flags_update(flags_update), .flags_in(flags_in), .general_register_window(grw),
    .window_ram_addr(wra), .core_enable(core_enable), .periph_enable(periph_enable),
    .boost_not_ok(boost_not_ok), .power_control(pwr), .interrupt_enable(ien),
    .breakpoint_address(bkp), .usb_diagnostic(diag), .usb_diagnostic_strobe(diag_strobe)
  );

  // Free-running 250 MHz clock.
  always #2 clk = ~clk;

  // Count diagnostic strobes so that one pulse per diagnostic write can be checked.
  always @(posedge clk) begin
    if (diag_strobe === 1'h1) strobes++;
  end

  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_data

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: resp got %h expected %h", $time, got, exp);
    end
  endtask : chk_resp

  task automatic stop_test;
    $display("checks %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  // Handshakes are judged at the falling edge, where they equal what the next rising edge sees.
  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] r;
    tb = 1'h0;
    @(posedge clk);
    awaddr <= {16'h0000, a};
    wdata <= {16'h0000, d};
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!tb) begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      r = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
    end
    bready <= 1'h0;
    chk_resp(r, er);
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [15:0] ed, input logic [1:0] er);
    logic ta, tr;
    tr = 1'h0;
    @(posedge clk);
    araddr <= {16'h0000, a};
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (!tr) begin
      @(negedge clk);
      ta = arvalid && arready;
      tr = rvalid;
      if (tr) chk_data(rdata, {16'h0000, ed});
      if (tr) chk_resp(rresp, er);
      @(posedge clk);
      if (ta) arvalid <= 1'h0;
    end
    rready <= 1'h0;
  endtask : rd

  // Present every register number and compare the RAM address one cycle later.
  task automatic win_chk(input logic [15:0] base);
    for (int n = 0; n < 16; n++) begin
      @(posedge clk);
      grw <= 4'(n);
      @(posedge clk);
      @(negedge clk);
      chk_data({16'h0000, wra}, {16'h0000, (base & 16'hffe0) | 16'(n << 1)});
    end
  endtask : win_chk

  // Cycles from one core pulse to the next, counted on settled falling-edge samples.
  task automatic period(output int p);
    p = 0;
    while (core_enable !== 1'h1 && p < 40) begin
      @(negedge clk);
      p++;
    end
    p = 0;
    do begin
      @(negedge clk);
      p++;
    end while (core_enable !== 1'h1 && p < 40);
  endtask : period

  // Watchdog: the tests need a few thousand cycles at most.
  initial begin
    #(4 * 20000);
    errors++;
    stop_test();
  end

  // Main sequence of tests.
  initial begin
    logic [15:0] e;
    int p;
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    rd(`ADDR_PROCESSOR_FLAGS, 16'h0000, `AXI_RESP_OKAY);
    rd(`ADDR_REGISTER_WINDOW_BASE, 16'h0100, `AXI_RESP_OKAY);
    rd(`ADDR_SILICON_REVISION, `SILICON_REVISION_CODE, `AXI_RESP_OKAY);
    rd(`ADDR_CORE_CLOCK_DIVIDER, 16'h000f, `AXI_RESP_OKAY);
    rd(`ADDR_POWER_CONTROL, 16'h0000, `AXI_RESP_OKAY);
    rd(`ADDR_INTERRUPT_ENABLE, 16'h0010, `AXI_RESP_OKAY);
    rd(`ADDR_BREAKPOINT_ADDRESS, 16'h0000, `AXI_RESP_OKAY);
    rd(`ADDR_USB_DIAGNOSTIC, 16'h0000, `AXI_RESP_OKAY);
    $display("test reset_values done");
    win_chk(16'h0100);
    wr(`ADDR_REGISTER_WINDOW_BASE, 16'hfbe0, 4'h3, `AXI_RESP_OKAY);
    rd(`ADDR_REGISTER_WINDOW_BASE, 16'hfbe0, `AXI_RESP_OKAY);
    win_chk(16'hfbe0);
    $display("test window done");
    wr(`ADDR_PROCESSOR_FLAGS, 16'hffff, 4'h3, `AXI_RESP_OKAY);
    rd(`ADDR_PROCESSOR_FLAGS, 16'h0000, `AXI_RESP_OKAY);
    wr(`ADDR_SILICON_REVISION, 16'h0000, 4'h3, `AXI_RESP_OKAY);
    rd(`ADDR_SILICON_REVISION, `SILICON_REVISION_CODE, `AXI_RESP_OKAY);
    wr(`ADDR_BREAKPOINT_ADDRESS, 16'hbeef, 4'h3, `AXI_RESP_OKAY);
    wr(`ADDR_BREAKPOINT_ADDRESS, 16'h0012, 4'h1, `AXI_RESP_OKAY);
    rd(`ADDR_BREAKPOINT_ADDRESS, 16'hbe12, `AXI_RESP_OKAY);
    chk_data({16'h0000, bkp}, 32'h0000be12);
    wr(`ADDR_USB_DIAGNOSTIC, 16'h1234, 4'h3, `AXI_RESP_OKAY);
    rd(`ADDR_USB_DIAGNOSTIC, 16'h0000, `AXI_RESP_OKAY);
    chk_data({16'h0000, diag}, 32'h00001234);
    chk_data(32'(strobes), 32'h1);
    wr(`ADDR_POWER_CONTROL, 16'hffff, 4'h3, `AXI_RESP_OKAY);
    boost_not_ok <= 1'h1;
    rd(`ADDR_POWER_CONTROL, 16'h5b97, `AXI_RESP_OKAY);
    chk_data({16'h0000, pwr}, {16'h0000, `POWER_CONTROL_MASK});
    wr(`ADDR_INTERRUPT_ENABLE, 16'hffff, 4'h3, `AXI_RESP_OKAY);
    rd(`ADDR_INTERRUPT_ENABLE, 16'h1bff, `AXI_RESP_OKAY);
    wr(`ADDR_INTERRUPT_ENABLE, 16'h0000, 4'h3, `AXI_RESP_OKAY);
    rd(`ADDR_INTERRUPT_ENABLE, 16'h0010, `AXI_RESP_OKAY);
    chk_data({16'h0000, ien}, 32'h00000010);
    wr(16'hc006, 16'h5555, 4'h3, `AXI_RESP_SLVERR);
    rd(16'hc006, 16'h0000, `AXI_RESP_SLVERR);
    $display("test access_kinds done");
    for (int i = 0; i < 6; i++) begin
      e = (i == 5) ? 16'h001f : 16'(16'h0001 << i);
      @(posedge clk);
      flags_in <= e[4:0];
      flags_update <= 1'h1;
      @(posedge clk);
      flags_update <= 1'h0;
      flags_in <= 5'h00;
      rd(`ADDR_PROCESSOR_FLAGS, e, `AXI_RESP_OKAY);
    end
    $display("test flags done");
    for (int i = 0; i < 4; i++) begin
      e = 16'(i * 5);
      wr(`ADDR_CORE_CLOCK_DIVIDER, e, 4'h1, `AXI_RESP_OKAY);
      rd(`ADDR_CORE_CLOCK_DIVIDER, e, `AXI_RESP_OKAY);
      repeat (3) period(p);
      chk_data(32'(p), {16'h0000, e} + 32'h1);
      chk_data({31'h0, periph_enable}, 32'h1);
    end
    $display("test divisor done");
    stop_test();
  end
endmodule : processor_control_regs_tb_top
